/* File: hdl/srap_consts.vh */
// Purpose: constants of the serial register access port
// Assumes: 15-bit register addresses, byte-wide registers
// Notes: trim reset values stand in for factory defaults
`ifndef SRAP_CONSTS_VH
`define SRAP_CONSTS_VH

// frame layout
`define SRAP_HDR_BITS 5'd16
`define SRAP_HDR_LAST 5'd15
`define SRAP_BYTE_LAST 3'd7
`define SRAP_RW_READ 1'b1

// register address windows
`define SRAP_OFS_BASE 15'h0330
`define SRAP_OFS_LAST 15'h033b
`define SRAP_GAIN_BASE 15'h0360
`define SRAP_GAIN_LAST 15'h0365
`define SRAP_FS_BASE 15'h0030
`define SRAP_FS_LAST 15'h0031

// storage index of each window's first byte and of the full-scale high byte, then the entry count
`define SRAP_IDX_OFS 5'h00
`define SRAP_IDX_GAIN 5'h0c
`define SRAP_IDX_FS 5'h12
`define SRAP_IDX_FS_HI 5'h13
`define SRAP_NUM_ENTRY 20

// reset values, and the byte read back from unmapped addresses
`define SRAP_RST_TRIM 8'h00
`define SRAP_RST_FS_LO 8'h00
`define SRAP_RST_FS_HI 8'h00
`define SRAP_UNMAPPED 8'h00

`endif

/* File: hdl/srap_sync.v */
// Purpose: two-flop synchroniser, one per bit
// Assumes: inputs are asynchronous to clk
// Notes: first stage feeds only the second stage
`timescale 1ns/1ns
module srap_sync
#(
  parameter WIDTH = 3
)
(
  clk,
  nrst,
  din,
  dout
);
  input wire clk;
  input wire nrst;
  input wire [WIDTH-1:0] din;
  output wire [WIDTH-1:0] dout;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      reg meta_q;
      reg sync_q;
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          meta_q <= 1'b0;
          sync_q <= 1'b0;
        end
        else
        begin
          meta_q <= din[g];
          sync_q <= meta_q;
        end
      end
      assign dout[g] = sync_q;
    end
  endgenerate
endmodule

/* File: hdl/srap_port.v */
// Purpose: serial register access port with trim register storage
// Assumes: sclk, port_select_n and sdi are asynchronous pins;
//   calibration and configuration inputs come from clk logic
// Notes: sdo_out / sdo_oe drive an external tri-state pad
//
// How it works
// [RQ1] host holds select low for whole access
// [RQ2] sample serial input on sclk rising edge
// [RQ3] no minimum sclk rate, pauses allowed
// [RQ4] 24-bit frames, most significant bit first
// [RQ5] multi-byte registers stored little-endian
// [RQ6] first bit: one reads, zero writes
// [RQ7] next 15 bits are register address
// [RQ8] write frame stores last eight bits
// [RQ9] read frame shifts register out, ignores input
// [RQ10] output undriven in writes and headers
// [RQ11] extra bytes stream while select stays low
// [RQ12] address steps by one per streamed byte
// [RQ13] direction bit picks increment or decrement
// [RQ14] address hold stops address advancing
// [RQ15] host avoids access during calibration
// [RQ16] separate offset trim for six cores
// [RQ17] offset calibration result loads offset trims; code loads it only while background_cal_enable is also set
// [RQ18] calibration never touches gain trims
// [RQ19] one full-scale trim for all inputs
// [RQ20] absent-core trims accepted but unused
// [RQ21] partial frame on release writes nothing
`timescale 1ns/1ns
`include "srap_consts.vh"
module srap_port
#(
  parameter CORES = 6,
  parameter ACTIVE_CORES = 6
)
(
  clk,
  nrst,
  sclk,
  port_select_n,
  sdi,
  sdo_out,
  sdo_oe,
  addr_direction_up,
  addr_hold,
  offset_cal_enable,
  background_cal_enable,
  cal_result_valid,
  cal_result_core,
  cal_result_value,
  core_offset_trim,
  core_gain_trim,
  fullscale_trim
);
  input wire clk;
  input wire nrst;
  input wire sclk;
  input wire port_select_n;
  input wire sdi;
  output reg sdo_out;
  output reg sdo_oe;
  input wire addr_direction_up;
  input wire addr_hold;
  input wire offset_cal_enable;
  input wire background_cal_enable;
  input wire cal_result_valid;
  input wire [2:0] cal_result_core;
  input wire [15:0] cal_result_value;
  output reg [CORES*16-1:0] core_offset_trim;
  output reg [CORES*8-1:0] core_gain_trim;
  output reg [15:0] fullscale_trim;

  // pin synchronisation
  wire [2:0] pins_s;
  wire sclk_s;
  wire sel_n_s;
  wire sdi_s;

  srap_sync #(.WIDTH(3)) u_sync
  (
    .clk(clk),
    .nrst(nrst),
    .din({sclk, port_select_n, sdi}),
    .dout(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign sel_n_s = pins_s[1];
  assign sdi_s = pins_s[0];

  // sclk edge detection on the synchronised copy
  reg sclk_prev_q;
  wire sclk_rise;
  wire sclk_fall;
  wire active;

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sclk_prev_q <= 1'b0;
    else
      sclk_prev_q <= sclk_s;
  end

  assign sclk_rise = sclk_s & ~sclk_prev_q; // RQ2
  assign sclk_fall = ~sclk_s & sclk_prev_q;
  assign active = ~sel_n_s; // RQ1

  // frame state
  reg in_hdr_q;
  reg [4:0] hdr_cnt_q;
  reg [15:0] hdr_q;
  reg rw_q;
  reg [14:0] addr_q;
  reg [2:0] bit_cnt_q;
  reg [7:0] wr_sh_q;
  reg [7:0] rd_sh_q;

  wire [15:0] hdr_nxt;
  wire [7:0] wr_byte;
  wire [14:0] step_addr;
  wire [14:0] nxt_addr;

  assign hdr_nxt = {hdr_q[14:0], sdi_s}; // RQ4
  assign wr_byte = {wr_sh_q[6:0], sdi_s}; // RQ4
  assign step_addr = addr_direction_up ? addr_q + 15'h0001
                                       : addr_q - 15'h0001; // RQ13
  assign nxt_addr = addr_hold ? addr_q : step_addr; // RQ12 RQ14

  // address decode into storage index
  function [5:0] map_addr;
    input [14:0] a;
    reg [14:0] d;
    begin
      d = 15'h0000;
      map_addr = 6'h00;
      if (a >= `SRAP_OFS_BASE && a <= `SRAP_OFS_LAST)
      begin
        d = a - `SRAP_OFS_BASE;
        map_addr = {1'b1, d[4:0] + `SRAP_IDX_OFS};
      end
      else if (a >= `SRAP_GAIN_BASE && a <= `SRAP_GAIN_LAST)
      begin
        d = a - `SRAP_GAIN_BASE;
        map_addr = {1'b1, d[4:0] + `SRAP_IDX_GAIN};
      end
      else if (a >= `SRAP_FS_BASE && a <= `SRAP_FS_LAST)
      begin
        d = a - `SRAP_FS_BASE;
        map_addr = {1'b1, d[4:0] + `SRAP_IDX_FS};
      end
    end
  endfunction

  // register storage
  reg [7:0] mem_q [0:`SRAP_NUM_ENTRY-1];

  wire [5:0] map_cur;
  wire [5:0] map_hdr;
  wire [5:0] map_nxt;
  wire [7:0] rd_hdr;
  wire [7:0] rd_nxt;

  assign map_cur = map_addr(addr_q);
  assign map_hdr = map_addr(hdr_nxt[14:0]);
  assign map_nxt = map_addr(nxt_addr);
  assign rd_hdr = map_hdr[5] ? mem_q[map_hdr[4:0]] : `SRAP_UNMAPPED;
  assign rd_nxt = map_nxt[5] ? mem_q[map_nxt[4:0]] : `SRAP_UNMAPPED;

  wire hdr_done;
  wire byte_done;
  wire spi_wr;
  wire cal_wr;
  wire [4:0] cal_idx;

  assign hdr_done = active & sclk_rise & in_hdr_q &
                    (hdr_cnt_q == `SRAP_HDR_LAST);
  assign byte_done = active & sclk_rise & ~in_hdr_q &
                     (bit_cnt_q == `SRAP_BYTE_LAST);
  assign spi_wr = byte_done & (rw_q != `SRAP_RW_READ) & map_cur[5]; // RQ8
  assign cal_wr = cal_result_valid & offset_cal_enable &
                  background_cal_enable &
                  (cal_result_core < CORES); // RQ17
  assign cal_idx = {cal_result_core, 1'b0} + `SRAP_IDX_OFS; // RQ16

  // frame sequencing, steps wait on sclk edges except the reset on release of select
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      in_hdr_q <= 1'b1;
      hdr_cnt_q <= 5'h00;
      hdr_q <= 16'h0000;
      rw_q <= 1'b0;
      addr_q <= 15'h0000;
      bit_cnt_q <= 3'h0;
      wr_sh_q <= 8'h00;
      rd_sh_q <= 8'h00;
    end
    else if (!active)
    begin
      // RQ21: release drops any partial frame
      in_hdr_q <= 1'b1;
      hdr_cnt_q <= 5'h00;
      bit_cnt_q <= 3'h0;
    end
    else if (sclk_rise) // RQ3
    begin
      if (in_hdr_q)
      begin
        hdr_q <= hdr_nxt;
        hdr_cnt_q <= hdr_cnt_q + 5'h01;
        if (hdr_done)
        begin
          rw_q <= hdr_nxt[15]; // RQ6
          addr_q <= hdr_nxt[14:0]; // RQ7
          in_hdr_q <= 1'b0;
          bit_cnt_q <= 3'h0;
          rd_sh_q <= rd_hdr;
        end
      end
      else
      begin
        wr_sh_q <= wr_byte;
        bit_cnt_q <= bit_cnt_q + 3'h1;
        if (byte_done)
        begin
          addr_q <= nxt_addr; // RQ11 RQ12
          rd_sh_q <= rd_nxt; // RQ9
        end
      end
    end
    else if (sclk_fall && !in_hdr_q)
      rd_sh_q <= {rd_sh_q[6:0], 1'b0}; // RQ9
  end

  // serial output, driven only in the data phase of reads
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0;
    end
    else if (!active || in_hdr_q || rw_q != `SRAP_RW_READ)
    begin
      sdo_out <= 1'b0;
      sdo_oe <= 1'b0; // RQ10
    end
    else if (sclk_fall)
    begin
      sdo_out <= rd_sh_q[7]; // RQ9
      sdo_oe <= 1'b1;
    end
  end

  // storage writes; serial write wins over a calibration result
  integer i;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      for (i = 0; i < `SRAP_NUM_ENTRY; i = i + 1)
        mem_q[i] <= `SRAP_RST_TRIM;
      mem_q[`SRAP_IDX_FS] <= `SRAP_RST_FS_LO;
      mem_q[`SRAP_IDX_FS_HI] <= `SRAP_RST_FS_HI;
    end
    else
    begin
      if (cal_wr)
      begin
        mem_q[cal_idx] <= cal_result_value[7:0]; // RQ5 RQ17
        mem_q[cal_idx + 5'h01] <= cal_result_value[15:8];
      end
      if (spi_wr)
        mem_q[map_cur[4:0]] <= wr_byte; // RQ8 RQ20
    end
  end

  // trim outputs; absent cores present zero whatever is stored
  genvar g;
  generate
    for (g = 0; g < CORES; g = g + 1)
    begin : g_core
      always @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          core_offset_trim[g*16 +: 16] <= 16'h0000;
          core_gain_trim[g*8 +: 8] <= 8'h00;
        end
        else if (g < ACTIVE_CORES) // RQ20
        begin
          core_offset_trim[g*16 +: 16] <=
            {mem_q[2*g+1], mem_q[2*g]}; // RQ5 RQ16
          core_gain_trim[g*8 +: 8] <=
            mem_q[g + `SRAP_IDX_GAIN]; // RQ18
        end
        else
        begin
          core_offset_trim[g*16 +: 16] <= 16'h0000;
          core_gain_trim[g*8 +: 8] <= 8'h00;
        end
      end
    end
  endgenerate

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      fullscale_trim <= 16'h0000;
    else
      fullscale_trim <= {mem_q[`SRAP_IDX_FS_HI],
                         mem_q[`SRAP_IDX_FS]}; // RQ19
  end
endmodule

/* File: dv/srap_port_checker.sv */
// Purpose: timing checks on the serial port pins and trims
// Assumes: serial pins stay quiet for 8 clk between frames
// Notes: bound to every srap_port instance
`timescale 1ns/1ns
module srap_port_checker
#(
  parameter CORES = 6
)
(
  input wire clk,
  input wire nrst,
  input wire sclk,
  input wire port_select_n,
  input wire sdo_out,
  input wire sdo_oe,
  input wire offset_cal_enable,
  input wire background_cal_enable,
  input wire cal_result_valid,
  input wire [2:0] cal_result_core,
  input wire [15:0] cal_result_value,
  input wire [CORES*16-1:0] core_offset_trim,
  input wire [CORES*8-1:0] core_gain_trim,
  input wire [15:0] fullscale_trim
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_oe_drop;
    $rose(port_select_n) |-> ##[0:5] !sdo_oe;
  endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("sdo kept on");
  property p_oe_idle;
    port_select_n [*8] |-> !sdo_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("sdo on idle");
  property p_hdr;
    $fell(port_select_n) |-> !sdo_oe [*8];
  endproperty
  a_hdr: assert property (p_hdr) else $error("sdo on in header");
  property p_sdo_chg;
    sdo_oe && $changed(sdo_out) |-> !sclk;
  endproperty
  a_sdo_chg: assert property (p_sdo_chg) else $error("sdo moved");
  property p_gain;
    port_select_n [*8] |-> $stable(core_gain_trim);
  endproperty
  a_gain: assert property (p_gain) else $error("gain moved");
  property p_fs;
    port_select_n [*8] |-> $stable(fullscale_trim);
  endproperty
  a_fs: assert property (p_fs) else $error("full-scale moved");
  property p_cal;
    cal_result_valid && offset_cal_enable && background_cal_enable &&
      cal_result_core == 3'h2 |->
      ##[2:3] core_offset_trim[47:32] == $past(cal_result_value, 2);
  endproperty
  a_cal: assert property (p_cal) else $error("offset not loaded");
  property p_core;
    port_select_n [*8] ##0 (cal_result_valid && cal_result_core != 3'h0)
      |-> ##1 $stable(core_offset_trim[15:0]) [*3];
  endproperty
  a_core: assert property (p_core) else $error("core 0 moved");
endmodule
bind srap_port srap_port_checker #(.CORES(CORES)) srap_port_checker_inst (.*);

/* File: dv/srap_host.sv */
// Purpose: serial host model driving the port pins
// Assumes: sclk low for hp ns, high for hp+1 ns, sdi set while low
// Notes: undriven sdo reads as inverse of last level
`timescale 1ns/1ns
module srap_host
(
  output reg sclk,
  output reg port_select_n,
  output reg sdi,
  input wire sdo_out,
  input wire sdo_oe
);
  reg lst = 1'b0;
  integer hp = 62;
  wire sdo = sdo_oe ? sdo_out : ~lst;
  initial
  begin
    sclk = 1'b0;
    port_select_n = 1'b1;
    sdi = 1'b0;
  end
  task xfer(input [31:0] v, input integer n, output [31:0] r);
    integer i;
    begin
      r = 32'h0;
      port_select_n = 1'b0;
      #hp;
      for (i = n - 1; i >= 0; i = i - 1)
      begin
        sdi = v[i];
        #hp;
        sclk = 1'b1;
        lst = sdo;
        r = {r[30:0], sdo};
        #(hp + 1);
        sclk = 1'b0;
      end
      #hp;
      port_select_n = 1'b1;
      #(2 * hp);
    end
  endtask
endmodule

/* File: dv/test_srap_port.sv */
// Purpose: self-checking bench for the serial register access port
// Assumes: srap_host drives the serial pins
// Notes: one frame runs with a stretched serial clock
`timescale 1ns/1ns
module test_srap_port;
  reg clk = 1'b0;
  reg nrst = 1'b0;
  wire sclk;
  wire port_select_n;
  wire sdi;
  wire sdo_out;
  wire sdo_oe;
  reg addr_direction_up = 1'b1;
  reg addr_hold = 1'b0;
  reg offset_cal_enable = 1'b0;
  reg background_cal_enable = 1'b0;
  reg cal_result_valid = 1'b0;
  reg [2:0] cal_result_core = 3'h0;
  reg [15:0] cal_result_value = 16'h0;
  wire [95:0] core_offset_trim;
  wire [47:0] core_gain_trim;
  wire [15:0] fullscale_trim;
  integer mismatches = 0;
  integer comparisons = 0;
  reg [31:0] r;
  srap_port #(.ACTIVE_CORES(5)) srap_port_inst (.*);
  srap_host srap_host_inst (.*);
  always #4 clk = ~clk;
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    comparisons = comparisons + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("wrong value at %0t: %h not %h", $time, seen, exp);
    end
  end
  endtask
  task x(input [31:0] v, input integer n);
    srap_host_inst.xfer(v, n, r);
  endtask
  task summarize;
  begin
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  end
  endtask
  task t_one;
  begin
    chk({core_offset_trim[15:0], fullscale_trim}, 32'h0);
    chk({core_gain_trim[15:0], 15'h0, sdo_oe}, 32'h0);
    x({1'b0, 15'h0330, 8'h5a}, 24);
    x({1'b0, 15'h0331, 8'hc3}, 24);
    chk(core_offset_trim[15:0], 16'hc35a);
    x({1'b1, 15'h0330, 8'hff}, 24);
    chk(r[7:0], 8'h5a);
    x({1'b1, 15'h0100, 8'hff}, 24);
    chk(r[7:0], 8'h00);
    srap_host_inst.hp = 300;
    x({1'b0, 15'h0361, 8'h3c}, 24);
    srap_host_inst.hp = 62;
    chk(core_gain_trim[15:8], 8'h3c);
    x({1'b0, 15'h0361, 4'h9}, 20);
    chk(core_gain_trim[15:8], 8'h3c);
  end
  endtask
  task t_str;
  begin
    x({1'b0, 15'h0030, 16'h1122}, 32);
    chk(fullscale_trim, 16'h2211);
    x({1'b1, 15'h0030, 16'hffff}, 32);
    chk(r[15:0], 16'h1122);
    @(negedge clk) addr_direction_up = 1'b0;
    x({1'b0, 15'h0365, 16'h4455}, 32);
    chk(core_gain_trim[47:32], 16'h0055);
    x({1'b1, 15'h0365, 8'hff}, 24);
    chk(r[7:0], 8'h44);
    @(negedge clk) addr_direction_up = 1'b1;
    addr_hold = 1'b1;
    x({1'b0, 15'h0360, 16'h6677}, 32);
    chk(core_gain_trim[15:0], 16'h3c77);
  end
  endtask
  task t_cal;
  begin
    @(negedge clk);
    offset_cal_enable = 1'b1;
    background_cal_enable = 1'b1;
    cal_result_core = 3'h2;
    cal_result_value = 16'hbeef;
    cal_result_valid = 1'b1;
    @(negedge clk) cal_result_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk(core_offset_trim[47:32], 16'hbeef);
    chk(core_offset_trim[15:0], 16'hc35a);
    chk(core_gain_trim[31:0], 32'h00003c77);
    background_cal_enable = 1'b0;
    cal_result_core = 3'h3;
    cal_result_valid = 1'b1;
    @(negedge clk) cal_result_valid = 1'b0;
    repeat (4) @(negedge clk);
    chk(core_offset_trim[63:48], 16'h0000);
  end
  endtask
  initial
  begin
    repeat (8) @(posedge clk);
    @(negedge clk) nrst = 1'b1;
    repeat (8) @(negedge clk);
    t_one;
    t_str;
    t_cal;
    summarize;
  end
  initial
  begin
    #300000;
    mismatches = mismatches + 1;
    summarize;
  end
endmodule
